// File: core/isp_map.vh
`ifndef ISP_MAP_VH
`define ISP_MAP_VH
// slave address fields
`define ISP_ADDR_TOP 3'h3
`define ISP_ADDR_HI_LOW 3'h4
`define ISP_GCALL 8'h00
`define ISP_HS_CODE 5'h01
`define ISP_PTR_RST 8'h00
// bit counter values
`define ISP_BIT_LAST 4'h7
`define ISP_BIT_ACK 4'h8
// deglitch lengths in ref_clk cycles
`define ISP_FILT_LS 3'h3
`define ISP_FILT_HS 3'h1
`define ISP_FILT_W 3
`endif

// File: core/isp_fifo.v
`timescale 1ns/1ps
module isp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // full and empty straight from the fill count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write, no reset needed on data
  always @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // isp_fifo

// File: core/isp_slave.v
// What this block does
// - one bit per clock; data sampled on clock rise, changed only while low
// - data fall with clock high is start, data rise is stop
// - repeated start handled exactly like a fresh start
// - after stop or address mismatch, ignore clock until next start
// - ninth bit acknowledges; drive data low across ninth clock high
// - not-acknowledge leaves data released across ninth clock high
// - address 011, variant bit, then 100 or 0 plus pins 1,0
// - never pull the clock line low
// - general call address zero is not acknowledged
// - works at any bus rate up to high-speed
// - low-speed filters at reset and after every stop
// - write: address, pointer, data, each acknowledged; a data byte only while the fifo has room
// - matching address byte is acknowledged
// - data byte written out on ack clock rise
// - repeated start keeps filter speed, stop returns to low speed
// - receiver on write, transmitter on read, always a slave
// - stop resets the register pointer to zero
// - read: slave sends bytes until master not-acknowledges
// - master code 00001xxx gets not-acknowledge and enables high speed
`timescale 1ns/1ps
`include "isp_map.vh"
module isp_slave #(
  parameter ALT_VARIANT = 1'b0,
  parameter FIFO_DEPTH = 8
) (
  input wire ref_clk,
  input wire reset,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire phase_select_pin_0,
  input wire phase_select_pin_1,
  input wire phase_select_pin_2,
  output wire wr_valid,
  input wire wr_ready,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data,
  output reg [7:0] rd_addr,
  input wire [7:0] rd_data,
  output wire hs_mode,
  output wire busy
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_PTR = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_MACK = 3'h5;
  localparam ST_HSCODE = 3'h6;

  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg [2:0] pin_meta_q;
  reg [2:0] pin_q;
  reg [`ISP_FILT_W-1:0] scl_cnt_q;
  reg [`ISP_FILT_W-1:0] sda_cnt_q;
  reg scl_f_q;
  reg sda_f_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg [7:0] tx_q;
  reg hs_q;
  reg drive_low_q;
  reg ack_q;
  reg push_q;
  reg [15:0] push_data_q;
  reg fall_armed_q;
  wire [`ISP_FILT_W-1:0] filt_len;
  wire scl_rise;
  wire scl_low_sync;
  wire start_det;
  wire stop_det;
  wire [6:0] own_addr;
  wire fifo_in_ready;
  wire [15:0] fifo_out;
  wire addr_match;

  // two-flop synchronisers on both bus lines and the straps
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      pin_meta_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      pin_meta_q <= {phase_select_pin_2, phase_select_pin_1, phase_select_pin_0};
      pin_q <= pin_meta_q;
    end
  end

  assign filt_len = hs_q ? `ISP_FILT_HS : `ISP_FILT_LS;

  // deglitch: accept a new level only after it holds filt_len cycles
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_cnt_q <= {`ISP_FILT_W{1'b0}};
      sda_cnt_q <= {`ISP_FILT_W{1'b0}};
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      if (scl_sync_q[1] == scl_f_q) begin
        scl_cnt_q <= {`ISP_FILT_W{1'b0}};
      end else if (scl_cnt_q >= filt_len - 1'b1) begin
        scl_f_q <= scl_sync_q[1];
        scl_cnt_q <= {`ISP_FILT_W{1'b0}};
      end else begin
        scl_cnt_q <= scl_cnt_q + 1'b1;
      end
      if (sda_sync_q[1] == sda_f_q) begin
        sda_cnt_q <= {`ISP_FILT_W{1'b0}};
      end else if (sda_cnt_q >= filt_len - 1'b1) begin
        sda_f_q <= sda_sync_q[1];
        sda_cnt_q <= {`ISP_FILT_W{1'b0}};
      end else begin
        sda_cnt_q <= sda_cnt_q + 1'b1;
      end
    end
  end

  // edge finding on the filtered levels; filtered values lag by one update
  reg scl_d1_q;
  reg sda_d1_q;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_f_q;
      sda_d1_q <= sda_f_q;
    end
  end
  // sample on filtered rise, shift out once the synchronised line is low
  // filter delay outlasts a short low phase, so output timing skips the filter;
  // a glitch may move data early, but the arm flag allows one update per bit
  assign scl_rise = scl_f_q & ~scl_d1_q;
  assign scl_low_sync = ~scl_sync_q[1];
  assign start_det = scl_f_q & scl_d1_q & sda_d1_q & ~sda_f_q;
  assign stop_det = scl_f_q & scl_d1_q & ~sda_d1_q & sda_f_q;

  // own address from variant and straps
  assign own_addr = {`ISP_ADDR_TOP, ALT_VARIANT[0],
    (pin_q[2] ? `ISP_ADDR_HI_LOW : {1'b0, pin_q[1], pin_q[0]})};
  assign addr_match = (sh_q[7:1] == own_addr);

  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  // open drain data: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_q;
  assign hs_mode = hs_q;
  assign busy = (st_q != ST_IDLE);
  // read address tracks the pointer
  always @* begin
    rd_addr = ptr_q;
  end

  // main byte engine
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= `ISP_PTR_RST;
      tx_q <= 8'h00;
      hs_q <= 1'b0;
      drive_low_q <= 1'b0;
      ack_q <= 1'b0;
      fall_armed_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 16'h0000;
    end else begin
      push_q <= 1'b0;
      if (stop_det) begin
        st_q <= ST_IDLE;
        drive_low_q <= 1'b0;
        fall_armed_q <= 1'b0;
        // stop drops back to low speed
        hs_q <= 1'b0;
        ptr_q <= `ISP_PTR_RST;
      end else if (start_det) begin
        // repeated start same as start, speed kept
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        drive_low_q <= 1'b0;
        fall_armed_q <= 1'b0;
        ack_q <= 1'b0;
      end else if (st_q != ST_IDLE && scl_rise) begin
        // no bus timeout anywhere, so any clock rate from zero works
        fall_armed_q <= 1'b1;
        if (bit_q <= `ISP_BIT_LAST) begin
          if (st_q != ST_RDATA) begin
            sh_q <= {sh_q[6:0], sda_f_q};
          end
          bit_q <= bit_q + 1'b1;
        end else begin
          bit_q <= 4'h0;
          case (st_q)
            ST_ADDR: begin
              if (ack_q) begin
                st_q <= sh_q[0] ? ST_RDATA : ST_PTR;
                tx_q <= rd_data;
              end else if (sh_q[7:3] == `ISP_HS_CODE) begin
                // master code: no ack, switch to fast filters
                hs_q <= 1'b1;
                st_q <= ST_IDLE;
              end else begin
                // mismatch ignores bus until next start
                st_q <= ST_IDLE;
              end
            end
            ST_PTR: begin
              // pointer byte first, data bytes after it
              ptr_q <= sh_q;
              st_q <= ST_WDATA;
            end
            ST_WDATA: begin
              if (ack_q) begin
                // byte handed out on ack clock rise
                push_q <= 1'b1;
                push_data_q <= {ptr_q, sh_q};
                ptr_q <= ptr_q + 8'h01;
              end
            end
            ST_RDATA: begin
              // master ack asks for more, nack ends
              if (!sda_f_q) begin
                tx_q <= rd_data;
              end else begin
                st_q <= ST_IDLE;
              end
            end
            default: begin
              st_q <= ST_IDLE;
            end
          endcase
        end
      end else if (st_q != ST_IDLE && fall_armed_q && scl_low_sync) begin
        fall_armed_q <= 1'b0;
        drive_low_q <= 1'b0;
        if (bit_q == `ISP_BIT_ACK && st_q != ST_RDATA) begin
          // ack for own address, pointer, or data with room
          // general call never matches own address
          ack_q <= (st_q == ST_ADDR) ? (addr_match && sh_q != `ISP_GCALL) :
            (st_q == ST_WDATA) ? fifo_in_ready : 1'b1;
          drive_low_q <= (st_q == ST_ADDR) ? (addr_match && sh_q != `ISP_GCALL) :
            (st_q == ST_WDATA) ? fifo_in_ready : 1'b1;
        end else if (st_q == ST_RDATA && bit_q <= `ISP_BIT_LAST) begin
          // transmit msb first; release for master ack
          drive_low_q <= ~tx_q[3'h7 - bit_q[2:0]];
          if (bit_q == `ISP_BIT_LAST) begin
            // pointer steps after each byte read
            ptr_q <= ptr_q + 8'h01;
          end
        end else if (st_q == ST_RDATA) begin
          drive_low_q <= 1'b0;
        end
      end
    end
  end

  // write port buffered; ack withheld when full so the master retries
  isp_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );
  assign wr_addr = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];
endmodule // isp_slave

// File: bench/isp_slave_asserts.sv
`timescale 1ns/1ps
module isp_slave_asserts (
  input wire ref_clk,
  input wire reset,
  input wire scl_in,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_oe,
  input wire wr_valid,
  input wire wr_ready,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_addr,
  input wire hs_mode,
  input wire busy
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // bus properties; a late ack release is kept out of the stop test
  a_no_stretch: assert property (!scl_oe) else $error("clock line driven");
  a_oe_when_busy: assert property (sda_oe |-> busy) else $error("data driven while idle");
  a_start_wakes: assert property (scl_in && $fell(sda_in) |-> ##[1:10] busy) else $error("start missed");
  a_stop_clears: assert property (scl_in && $rose(sda_in) && !$past(sda_oe) |->
    ##[1:10] (!hs_mode && rd_addr == 8'h00)) else $error("stop did not clear");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_addr))
    else $error("write word dropped");
  a_push_acked: assert property ($rose(wr_valid) |-> sda_oe || $past(sda_oe)) else $error("store without ack");
  a_hs_entry: assert property ($rose(hs_mode) |-> $past(busy) && !busy && !sda_oe) else $error("master code acked");
  a_hs_exit: assert property ($fell(hs_mode) |-> ##[0:2] rd_addr == 8'h00) else $error("speed left without stop");
  // main scenarios reached
  c_stall: cover property (wr_valid && !wr_ready ##1 wr_valid);
  c_hs: cover property ($rose(hs_mode));
  c_idle: cover property ($fell(busy));
endmodule // isp_slave_asserts
bind isp_slave isp_slave_asserts chk (.ref_clk, .reset, .scl_in, .scl_oe, .sda_in, .sda_oe, .wr_valid, .wr_ready,
  .wr_addr, .wr_data, .rd_addr, .hs_mode, .busy);

// File: bench/isp_bus_master.sv
`timescale 1ns/1ps
module isp_bus_master (
  input wire sda_line,
  output reg scl_pull_q,
  output reg sda_pull_q
);
  // released lines float high through the pull-ups
  initial begin
    scl_pull_q = 1'b0;
    sda_pull_q = 1'b0;
  end
  // start, also repeated start from clock low
  task start; begin
    #80 sda_pull_q = 1'b0;
    #80 scl_pull_q = 1'b0;
    #160 sda_pull_q = 1'b1;
    #160 scl_pull_q = 1'b1;
  end endtask
  task stop; begin
    #80 sda_pull_q = 1'b1;
    #80 scl_pull_q = 1'b0;
    #160 sda_pull_q = 1'b0;
    #160;
  end endtask
  // data moves mid low phase, sampled late in high phase
  task bits(input [8:0] d, output [8:0] r);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        #80 sda_pull_q = !d[i];
        #80 scl_pull_q = 1'b0;
        #150 r[i] = sda_line;
        #10 scl_pull_q = 1'b1;
      end
    end
  endtask
endmodule // isp_bus_master

// File: bench/isp_slave_bench.sv
`timescale 1ns/1ps
module isp_slave_bench;
  reg ref_clk, reset, wr_ready, stall;
  reg [2:0] pins;
  reg [7:0] rd_data, me;
  reg [8:0] r;
  reg [7:0] mem [0:255];
  reg [15:0] q [$];
  wire scl_oe, sda_oe, sda_out, wr_valid, hs_mode, busy, scl_pull_q, sda_pull_q;
  wire [7:0] wr_addr, wr_data, rd_addr;
  wire scl = !(scl_pull_q || scl_oe);
  wire sda = !(sda_pull_q || (sda_oe && !sda_out));
  integer errors, check_count, seed, ptr, i, j;
  isp_slave dut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .phase_select_pin_0(pins[0]), .phase_select_pin_1(pins[1]),
    .phase_select_pin_2(pins[2]), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .hs_mode(hs_mode), .busy(busy));
  isp_bus_master m (.sda_line(sda), .scl_pull_q(scl_pull_q), .sda_pull_q(sda_pull_q));
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = !ref_clk;
  end
  task chk(input [15:0] g, input [15:0] e); begin
    check_count = check_count + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  end endtask
  task print_verdict; begin
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end endtask
  // one byte out, ack compared with the model
  task tx(input [7:0] d, input a); begin
    m.bits({d, 1'b1}, r);
    chk(r[0], !a);
  end endtask
  // sink stalls during writes so fifo occupancy equals the queue length
  task wr(input [7:0] p, input integer n);
    reg [7:0] d;
    begin
      stall = 1;
      m.start;
      tx({me[6:0], 1'b0}, 1);
      tx(p, 1);
      ptr = p;
      for (j = 0; j < n; j = j + 1) begin
        d = $random(seed);
        if (q.size() < 8) begin
          q.push_back({ptr[7:0], d});
          tx(d, 1);
          ptr = (ptr + 1) % 256;
        end else
          tx(d, 0);
      end
      m.stop;
      ptr = 0;
      stall = 0;
    end
  endtask
  // slave sends, master acks all but the last
  task rd(input integer n); begin
    m.start;
    tx({me[6:0], 1'b1}, 1);
    for (j = 0; j < n; j = j + 1) begin
      m.bits({8'hff, j == n - 1}, r);
      chk(r[8:1], mem[ptr[7:0]]);
      ptr = (ptr + 1) % 256;
    end
  end endtask
  // inputs move on the falling edge
  always @(negedge ref_clk) begin
    wr_ready <= !stall & $random(seed);
    rd_data <= mem[rd_addr];
  end
  // every accepted word against the expected queue
  always @(posedge ref_clk)
    if (wr_valid === 1'b1 && wr_ready) chk({wr_addr, wr_data}, q.pop_front());
  initial begin
    errors = 0;
    check_count = 0;
    seed = 55;
    stall = 0;
    pins = 0;
    wr_ready = 0;
    rd_data = 0;
    reset = 1;
    ptr = 0;
    for (i = 0; i < 256; i = i + 1) mem[i] = $random(seed);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) reset = 0;
    for (i = 0; i < 8; i = i + 1) begin
      @(negedge ref_clk) pins = i;
      me = {1'b0, 3'b011, 1'b0, pins[2] ? 3'b100 : {1'b0, pins[1:0]}};
      repeat (6) @(negedge ref_clk);
      #7 wr(i * 37, 2);
      m.start;
      tx(8'h00, 0);
      tx({me[6:0], 1'b0}, 0);
      m.stop;
      m.start;
      tx({me[6:0] ^ 7'h01, 1'b0}, 0);
      tx({me[6:0], 1'b0}, 0);
      m.stop;
    end
    wr(8'hf8, 9);
    // a fresh byte to the refused byte's pointer once the sink has drained
    repeat (60) @(negedge ref_clk);
    #7 wr(8'h00, 1);
    m.start;
    tx({me[6:0], 1'b0}, 1);
    tx(8'hfe, 1);
    ptr = 8'hfe;
    rd(3);
    m.stop;
    ptr = 0;
    rd(1);
    m.stop;
    // master code always precedes any high-speed traffic
    for (i = 8; i < 16; i = i + 7) begin
      m.start;
      tx(i, 0);
      m.start;
      tx({me[6:0], 1'b0}, 1);
      chk(hs_mode, 1);
      m.stop;
      repeat (12) @(negedge ref_clk);
      chk(hs_mode, 0);
      #7;
    end
    repeat (200) @(negedge ref_clk);
    chk(q.size(), 0);
    print_verdict;
  end
  // cut a hang short
  initial begin
    #1000000;
    errors = errors + 1;
    print_verdict;
  end
endmodule // isp_slave_bench
